// file: verilog/rcs_top.sv
// Reset-cause tracking, status flags, resume address and start-up delay
//
// Added by the designer: the register addresses and the APB interface to the registers.
`default_nettype none
module rcs_top #(
   parameter int PWRT_CYCLES = rcs_pkg::PWRT_CYCLES,
   parameter int OST_PERIODS = rcs_pkg::OST_OSC_PERIODS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic poweron_pulse,
   input wire logic brownout_n,
   input wire logic master_clear_n,
   input wire logic watchdog_timeout,
   input wire logic irq_wake,
   input wire logic global_irq_enable,
   input wire logic sleeping,
   input wire logic osc_tick,
   input wire logic [12:0] current_pc,
   output logic [12:0] resume_pc,
   output logic cpu_hold,
   output logic wake_irq_flag_set,
   output logic irq
);
   typedef struct packed {
      logic [1:0] power_status;
      logic [7:0] cpu_status;
      logic [12:0] resume_pc;
      logic [3:0] config_bits;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic [31:0] prdata;
      logic wake_flag;
      logic master_clear_n_d;
      logic bor_d;
      logic wake_d;
      logic delay_start;
      logic use_pwrt;
      logic use_ost;
      logic [2:0] last_cause;
   } rcs_state_t;
   rcs_state_t st_ff;
   rcs_state_t nxt_st;

   logic master_clear_n_sync_n;
   logic bor_sync_n;
   logic por_sync;
   logic wdt_sync;
   logic wake_sync;
   logic delay_busy;
   logic [1:0] osc_mode;
   logic crystal;
   rcs_pkg::rcs_event_t ev;
   logic wr;
   logic rd;
   logic addr_ok;
   logic master_clear_n_fall;
   logic bor_fall;
   logic wake_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; active-low pins idle high through the reset_val xor
   rcs_sync u_sync_master_clear_n (.pclk(pclk), .presetn(presetn), .async_in(~master_clear_n), .reset_val(1'b1),
      .sync_out(master_clear_n_sync_n));
   rcs_sync u_sync_bor (.pclk(pclk), .presetn(presetn), .async_in(~brownout_n), .reset_val(1'b1),
      .sync_out(bor_sync_n));
   rcs_sync u_sync_por (.pclk(pclk), .presetn(presetn), .async_in(poweron_pulse), .reset_val(1'b0),
      .sync_out(por_sync));
   rcs_sync u_sync_wdt (.pclk(pclk), .presetn(presetn), .async_in(watchdog_timeout), .reset_val(1'b0),
      .sync_out(wdt_sync));
   rcs_sync u_sync_wake (.pclk(pclk), .presetn(presetn), .async_in(irq_wake), .reset_val(1'b0),
      .sync_out(wake_sync));

   rcs_delay #(.PWRT_CYCLES(PWRT_CYCLES), .OST_PERIODS(OST_PERIODS)) u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .start(st_ff.delay_start),
      .use_pwrt(st_ff.use_pwrt),
      .use_ost(st_ff.use_ost),
      .osc_tick(osc_tick),
      .busy(delay_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event classification, power-on beats brown-out beats the rest
   assign osc_mode = st_ff.config_bits[rcs_pkg::LSB_OSC_MODE +: 2];
   assign crystal = (osc_mode != rcs_pkg::OSC_RC);
   // Edge detects; delayed copies reset to the idle level of each pin
   assign master_clear_n_fall = !master_clear_n_sync_n && st_ff.master_clear_n_d;
   assign bor_fall = !bor_sync_n && st_ff.bor_d;
   // Wake counts once per rising edge so the flag pulse stays one cycle
   assign wake_rise = wake_sync && !st_ff.wake_d;
   always_comb begin
      ev = rcs_pkg::RCS_EV_NONE;
      if (por_sync) begin
         ev = rcs_pkg::RCS_EV_POR;
      end else if (bor_fall && st_ff.config_bits[rcs_pkg::BIT_BOR_EN]) begin
         ev = rcs_pkg::RCS_EV_BOR;
      end else if (master_clear_n_fall) begin
         ev = sleeping ? rcs_pkg::RCS_EV_MASTER_CLEAR_N_SLEEP : rcs_pkg::RCS_EV_MASTER_CLEAR_N_RUN;
      end else if (wdt_sync) begin
         ev = sleeping ? rcs_pkg::RCS_EV_WDT_WAKE : rcs_pkg::RCS_EV_WDT_RESET;
      end else if (wake_rise && sleeping) begin
         ev = rcs_pkg::RCS_EV_IRQ_WAKE;
      end
   end

   // APB decode; zero wait states
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   always_comb begin
      addr_ok = 1'b0;
      if (paddr == rcs_pkg::OFF_POWER_STATUS) begin
         addr_ok = 1'b1;
      end else if (paddr == rcs_pkg::OFF_CPU_STATUS) begin
         addr_ok = 1'b1;
      end else if (paddr == rcs_pkg::OFF_RESUME_PC) begin
         addr_ok = 1'b1;
      end else if (paddr == rcs_pkg::OFF_CONFIG) begin
         addr_ok = 1'b1;
      end else if (paddr == rcs_pkg::OFF_IRQ_STATUS) begin
         addr_ok = 1'b1;
      end else if (paddr == rcs_pkg::OFF_IRQ_MASK) begin
         addr_ok = 1'b1;
      end else if (paddr == rcs_pkg::OFF_CONTROL) begin
         addr_ok = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state: cause flags, resume address, registers
   always_comb begin
      nxt_st = st_ff;
      nxt_st.master_clear_n_d = master_clear_n_sync_n;
      nxt_st.bor_d = bor_sync_n;
      nxt_st.wake_d = wake_sync;
      nxt_st.delay_start = 1'b0;
      nxt_st.wake_flag = 1'b0;

      // Software writes first so any hardware event below overrides them
      if (wr) begin
         if (paddr == rcs_pkg::OFF_POWER_STATUS) begin
            nxt_st.power_status = pwdata[1:0];
         end else if (paddr == rcs_pkg::OFF_CPU_STATUS) begin
            // Flag bits are read-only to software
            nxt_st.cpu_status[7:5] = pwdata[7:5];
            nxt_st.cpu_status[2:0] = pwdata[2:0];
         end else if (paddr == rcs_pkg::OFF_CONFIG) begin
            nxt_st.config_bits = pwdata[3:0];
         end else if (paddr == rcs_pkg::OFF_IRQ_STATUS) begin
            nxt_st.irq_status = st_ff.irq_status & ~pwdata[3:0];
         end else if (paddr == rcs_pkg::OFF_IRQ_MASK) begin
            nxt_st.irq_mask = pwdata[3:0];
         end
      end

      // Flags and PC settle in the cycle the event is seen, before hold drops
      case (ev)
         rcs_pkg::RCS_EV_POR: begin
            nxt_st.power_status[rcs_pkg::BIT_POWERON] = 1'b0;
            nxt_st.cpu_status = rcs_pkg::CPU_STATUS_POR;
            nxt_st.resume_pc = rcs_pkg::PC_RESET;
         end
         rcs_pkg::RCS_EV_BOR: begin
            nxt_st.power_status[rcs_pkg::BIT_BROWNOUT] = 1'b0;
            nxt_st.cpu_status = rcs_pkg::CPU_STATUS_POR;
            nxt_st.resume_pc = rcs_pkg::PC_RESET;
         end
         rcs_pkg::RCS_EV_MASTER_CLEAR_N_RUN: begin
            nxt_st.cpu_status = st_ff.cpu_status & rcs_pkg::CPU_STATUS_KEEP_MASTER_CLEAR_N;
            nxt_st.resume_pc = rcs_pkg::PC_RESET;
         end
         rcs_pkg::RCS_EV_MASTER_CLEAR_N_SLEEP: begin
            nxt_st.cpu_status = st_ff.cpu_status & rcs_pkg::CPU_STATUS_KEEP_MASTER_CLEAR_N;
            nxt_st.cpu_status[rcs_pkg::BIT_TIMEOUT] = 1'b1;
            nxt_st.cpu_status[rcs_pkg::BIT_POWERDOWN] = 1'b0;
            nxt_st.resume_pc = rcs_pkg::PC_RESET;
         end
         rcs_pkg::RCS_EV_WDT_RESET: begin
            nxt_st.cpu_status = st_ff.cpu_status & rcs_pkg::CPU_STATUS_KEEP_MASTER_CLEAR_N;
            nxt_st.cpu_status[rcs_pkg::BIT_TIMEOUT] = 1'b0;
            nxt_st.cpu_status[rcs_pkg::BIT_POWERDOWN] = 1'b1;
            nxt_st.resume_pc = rcs_pkg::PC_RESET;
         end
         rcs_pkg::RCS_EV_WDT_WAKE: begin
            nxt_st.cpu_status[rcs_pkg::BIT_TIMEOUT] = 1'b0;
            nxt_st.cpu_status[rcs_pkg::BIT_POWERDOWN] = 1'b0;
            nxt_st.resume_pc = current_pc + 13'h1;
         end
         rcs_pkg::RCS_EV_IRQ_WAKE: begin
            nxt_st.cpu_status[rcs_pkg::BIT_TIMEOUT] = 1'b1;
            nxt_st.cpu_status[rcs_pkg::BIT_POWERDOWN] = 1'b0;
            nxt_st.resume_pc = global_irq_enable ? rcs_pkg::PC_IRQ_VECTOR : current_pc + 13'h1;
            nxt_st.wake_flag = 1'b1;
         end
         default: begin
         end
      endcase

      if (ev != rcs_pkg::RCS_EV_NONE) begin
         nxt_st.last_cause = 3'(ev);
         // Sticky event bits: set beats a same-cycle clear
         nxt_st.irq_status[0] = 1'b1;
         if (ev == rcs_pkg::RCS_EV_POR || ev == rcs_pkg::RCS_EV_BOR) begin
            nxt_st.irq_status[1] = 1'b1;
         end
         if (ev == rcs_pkg::RCS_EV_WDT_RESET || ev == rcs_pkg::RCS_EV_WDT_WAKE) begin
            nxt_st.irq_status[2] = 1'b1;
         end
         if (ev == rcs_pkg::RCS_EV_IRQ_WAKE || ev == rcs_pkg::RCS_EV_WDT_WAKE) begin
            nxt_st.irq_status[3] = 1'b1;
         end
      end

      // Start-up delay selection by mode and cause
      nxt_st.use_pwrt = 1'b0;
      nxt_st.use_ost = 1'b0;
      if (ev == rcs_pkg::RCS_EV_POR) begin
         nxt_st.delay_start = 1'b1;
         // RC mode has no power-up disable column; timer always applied there
         nxt_st.use_pwrt = !st_ff.config_bits[rcs_pkg::BIT_PWRT_EN_N] || !crystal;
         nxt_st.use_ost = crystal;
      end else if (ev == rcs_pkg::RCS_EV_BOR) begin
         nxt_st.delay_start = 1'b1;
         nxt_st.use_pwrt = 1'b1;
         nxt_st.use_ost = crystal;
      end else if (ev == rcs_pkg::RCS_EV_WDT_WAKE || ev == rcs_pkg::RCS_EV_IRQ_WAKE) begin
         nxt_st.delay_start = crystal;
         nxt_st.use_ost = crystal;
      end

      // Read data registered in setup phase
      nxt_st.prdata = 32'h0;
      if (rd) begin
         if (paddr == rcs_pkg::OFF_POWER_STATUS) begin
            nxt_st.prdata = {30'h0, st_ff.power_status};
         end else if (paddr == rcs_pkg::OFF_CPU_STATUS) begin
            nxt_st.prdata = {24'h0, st_ff.cpu_status};
         end else if (paddr == rcs_pkg::OFF_RESUME_PC) begin
            nxt_st.prdata = {19'h0, st_ff.resume_pc};
         end else if (paddr == rcs_pkg::OFF_CONFIG) begin
            nxt_st.prdata = {28'h0, st_ff.config_bits};
         end else if (paddr == rcs_pkg::OFF_IRQ_STATUS) begin
            nxt_st.prdata = {28'h0, st_ff.irq_status};
         end else if (paddr == rcs_pkg::OFF_IRQ_MASK) begin
            nxt_st.prdata = {28'h0, st_ff.irq_mask};
         end else if (paddr == rcs_pkg::OFF_CONTROL) begin
            // Brown-out flag valid only with detection on
            nxt_st.prdata = {26'h0, st_ff.config_bits[rcs_pkg::BIT_BOR_EN], delay_busy, 1'b0,
               st_ff.last_cause};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; power-on values after async reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.cpu_status <= rcs_pkg::CPU_STATUS_POR;
         st_ff.config_bits <= rcs_pkg::CONFIG_RESET;
         st_ff.master_clear_n_d <= 1'b1;
         st_ff.bor_d <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = st_ff.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign resume_pc = st_ff.resume_pc;
   // Hold the core while a delay runs, its start is pending or master_clear_n is held low
   assign cpu_hold = delay_busy || st_ff.delay_start || !master_clear_n_sync_n;
   assign wake_irq_flag_set = st_ff.wake_flag;
   assign irq = |(st_ff.irq_status & st_ff.irq_mask);
endmodule : rcs_top
`default_nettype wire

// file: verilog/rcs_pkg.sv
// Package: register map, field layout, reset values and timing counts of the reset-cause block
`default_nettype none
package rcs_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] OFF_POWER_STATUS = 12'h000;
   localparam logic [11:0] OFF_CPU_STATUS = 12'h004;
   localparam logic [11:0] OFF_RESUME_PC = 12'h008;
   localparam logic [11:0] OFF_CONFIG = 12'h00c;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
   localparam logic [11:0] OFF_CONTROL = 12'h018;
   // Power status register fields
   localparam int BIT_BROWNOUT = 0;
   localparam int BIT_POWERON = 1;
   // Processor status fields
   localparam int BIT_POWERDOWN = 3;
   localparam int BIT_TIMEOUT = 4;
   localparam logic [7:0] CPU_STATUS_POR = 8'h18;
   localparam logic [7:0] CPU_STATUS_KEEP_MASTER_CLEAR_N = 8'h1f;
   // Program counter values
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
   // Config register fields
   localparam int BIT_PWRT_EN_N = 0;
   localparam int BIT_BOR_EN = 1;
   localparam int LSB_OSC_MODE = 2;
   localparam logic [1:0] OSC_LP = 2'h0;
   localparam logic [1:0] OSC_XT = 2'h1;
   localparam logic [1:0] OSC_HS = 2'h2;
   localparam logic [1:0] OSC_RC = 2'h3;
   localparam logic [3:0] CONFIG_RESET = 4'h0;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PWRT_MS = 72;
   localparam int PWRT_CYCLES = (PWRT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int OST_OSC_PERIODS = 1024;
   // Reset / wake causes
   typedef enum logic [2:0] {
      RCS_EV_NONE = 3'h0,
      RCS_EV_POR = 3'h1,
      RCS_EV_BOR = 3'h2,
      RCS_EV_MASTER_CLEAR_N_RUN = 3'h3,
      RCS_EV_MASTER_CLEAR_N_SLEEP = 3'h4,
      RCS_EV_WDT_RESET = 3'h5,
      RCS_EV_WDT_WAKE = 3'h6,
      RCS_EV_IRQ_WAKE = 3'h7
   } rcs_event_t;
endpackage : rcs_pkg
`default_nettype wire

// file: verilog/rcs_sync.sv
// Three-stage synchroniser with agreement check for one async pin
`default_nettype none
module rcs_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   input wire logic reset_val,
   output logic sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } rcs_sync_st_t;
   rcs_sync_st_t st_ff;
   rcs_sync_st_t nxt_st;

   // Output moves only once stages two and three agree
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = async_in;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      if (st_ff.s2 == st_ff.s3) begin
         nxt_st.out = st_ff.s3;
      end
   end

   // Reset value is a constant tie-off at the instance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.out ^ reset_val;
endmodule : rcs_sync
`default_nettype wire

// file: verilog/rcs_delay.sv
// Start-up delay timer: power-up part then oscillator part
`default_nettype none
module rcs_delay #(
   parameter int PWRT_CYCLES = rcs_pkg::PWRT_CYCLES,
   parameter int OST_PERIODS = rcs_pkg::OST_OSC_PERIODS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic use_pwrt,
   input wire logic use_ost,
   input wire logic osc_tick,
   output logic busy
);
   typedef enum logic [1:0] {
      RCS_D_IDLE = 2'b00,
      RCS_D_PWRT = 2'b01,
      RCS_D_OST = 2'b11
   } rcs_dstate_t;
   typedef struct packed {
      rcs_dstate_t state;
      logic [31:0] cnt;
      logic osc_startup_delay;
   } rcs_delay_st_t;
   rcs_delay_st_t st_ff;
   rcs_delay_st_t nxt_st;

   // Power-up leg counts pclk, oscillator leg counts osc ticks
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.state)
         RCS_D_IDLE: begin
            if (start) begin
               nxt_st.osc_startup_delay = use_ost;
               if (use_pwrt) begin
                  nxt_st.state = RCS_D_PWRT;
                  nxt_st.cnt = 32'(PWRT_CYCLES);
               end else if (use_ost) begin
                  nxt_st.state = RCS_D_OST;
                  nxt_st.cnt = 32'(OST_PERIODS);
               end
            end
         end
         RCS_D_PWRT: begin
            if (st_ff.cnt <= 32'h1) begin
               nxt_st.state = st_ff.osc_startup_delay ? RCS_D_OST : RCS_D_IDLE;
               nxt_st.cnt = 32'(OST_PERIODS);
            end else begin
               nxt_st.cnt = st_ff.cnt - 32'h1;
            end
         end
         RCS_D_OST: begin
            if (osc_tick) begin
               if (st_ff.cnt <= 32'h1) begin
                  nxt_st.state = RCS_D_IDLE;
               end else begin
                  nxt_st.cnt = st_ff.cnt - 32'h1;
               end
            end
         end
         default: nxt_st.state = RCS_D_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = (st_ff.state != RCS_D_IDLE);
endmodule : rcs_delay
`default_nettype wire

// file: testbench/rcs_top_asserts.sv
// Checker: port-level timing relations of the reset-cause block
`default_nettype none
module rcs_top_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic poweron_pulse,
   input wire logic master_clear_n,
   input wire logic watchdog_timeout,
   input wire logic irq_wake,
   input wire logic global_irq_enable,
   input wire logic sleeping,
   input wire logic [12:0] current_pc,
   input wire logic [12:0] resume_pc,
   input wire logic cpu_hold,
   input wire logic wake_irq_flag_set
);
   timeunit 1ns;
   timeprecision 1ps;
   logic map_ok;
   // Aligned word inside the seven-register window
   assign map_ok = (paddr[1:0] == 2'h0) && (paddr <= rcs_pkg::OFF_CONTROL);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   slave_err_a: assert property (psel && penable |-> pslverr == !map_ok)
      else $error("slave error does not follow address decode");
   rdata_zero_a: assert property (!(psel && !penable) || !map_ok |=> prdata == 32'h0)
      else $error("read data not zero outside a mapped access");
   irq_vector_a: assert property ($rose(irq_wake) && sleeping && global_irq_enable
      |-> ##[2:8] resume_pc == rcs_pkg::PC_IRQ_VECTOR)
      else $error("interrupt wake did not vector");
   wake_pc_a: assert property ($rose(irq_wake) && sleeping && !global_irq_enable && $stable(current_pc)
      |-> ##[2:8] resume_pc == current_pc + 13'h1)
      else $error("wake did not resume at next address");
   wdt_pc_a: assert property ($rose(watchdog_timeout) && !sleeping |-> ##[2:8] resume_pc == rcs_pkg::PC_RESET)
      else $error("watchdog reset did not clear resume address");
   wake_flag_a: assert property ($rose(irq_wake) && sleeping |-> ##[2:8] wake_irq_flag_set)
      else $error("causing interrupt flag not set on wake");
   flag_pulse_a: assert property (wake_irq_flag_set |=> !wake_irq_flag_set)
      else $error("wake flag pulse longer than one cycle");
   por_hold_a: assert property ($rose(poweron_pulse) |-> ##[2:8] cpu_hold)
      else $error("power-on did not hold the processor");
   master_clear_n_hold_a: assert property (!master_clear_n [*8] |-> cpu_hold)
      else $error("processor runs while external reset held");
endmodule : rcs_top_asserts
bind rcs_top rcs_top_asserts rcs_top_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .poweron_pulse(poweron_pulse),
   .master_clear_n(master_clear_n), .watchdog_timeout(watchdog_timeout), .irq_wake(irq_wake),
   .global_irq_enable(global_irq_enable), .sleeping(sleeping), .current_pc(current_pc),
   .resume_pc(resume_pc), .cpu_hold(cpu_hold), .wake_irq_flag_set(wake_irq_flag_set));
`default_nettype wire

// file: testbench/testbench.sv
// Testbench: register-level reset-cause scenarios over APB
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] PS = rcs_pkg::OFF_POWER_STATUS;
   localparam logic [11:0] CS = rcs_pkg::OFF_CPU_STATUS;
   localparam logic [11:0] PC = rcs_pkg::OFF_RESUME_PC;
   localparam logic [11:0] CF = rcs_pkg::OFF_CONFIG;
   localparam logic [11:0] IS = rcs_pkg::OFF_IRQ_STATUS;
   localparam logic [11:0] IM = rcs_pkg::OFF_IRQ_MASK;
   localparam logic [11:0] CT = rcs_pkg::OFF_CONTROL;
   localparam logic [31:0] ALL = 32'hffffffff;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic poweron_pulse = 1'b0;
   logic brownout_n = 1'b1;
   logic master_clear_n = 1'b1;
   logic watchdog_timeout = 1'b0;
   logic irq_wake = 1'b0;
   logic global_irq_enable = 1'b0;
   logic sleeping = 1'b0;
   logic osc_tick = 1'b0;
   logic [1:0] tdiv = 2'h0;
   logic [12:0] current_pc = 13'h0123;
   logic [31:0] prdata;
   logic [12:0] resume_pc;
   logic pready, pslverr, last_err, cpu_hold, wake_irq_flag_set, irq;
   int error_cnt = 0;
   int checked = 0;
   int hcnt = 0;
   int hlen = 0;
   // Counts shortened so the start-up delay fits a short run
   rcs_top #(.PWRT_CYCLES(20), .OST_PERIODS(8)) rcs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .poweron_pulse(poweron_pulse), .brownout_n(brownout_n), .master_clear_n(master_clear_n),
      .watchdog_timeout(watchdog_timeout), .irq_wake(irq_wake), .global_irq_enable(global_irq_enable),
      .sleeping(sleeping), .osc_tick(osc_tick), .current_pc(current_pc), .resume_pc(resume_pc),
      .cpu_hold(cpu_hold), .wake_irq_flag_set(wake_irq_flag_set), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 pclk = ~pclk;
   end
   // Oscillator period of four bus clocks; hold length measured in cycles
   always @(posedge pclk) begin
      tdiv <= tdiv + 2'h1;
      osc_tick <= (tdiv == 2'h3);
      if (cpu_hold === 1'b1) hcnt <= hcnt + 1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk
   // One APB transfer; request held until pready seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait ends once pready is high; the watchdog is its only bound
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask : rd
   // Pin event, then wait (bounded only by the watchdog) for the start-up delay to finish
   task automatic ev(input int k, input int n);
      int h0;
      @(posedge pclk);
      h0 = hcnt;
      case (k)
         0: poweron_pulse <= 1'b1;
         1: brownout_n <= 1'b0;
         2: master_clear_n <= 1'b0;
         3: watchdog_timeout <= 1'b1;
         default: irq_wake <= 1'b1;
      endcase
      tick(n);
      poweron_pulse <= 1'b0;
      brownout_n <= 1'b1;
      master_clear_n <= 1'b1;
      watchdog_timeout <= 1'b0;
      irq_wake <= 1'b0;
      tick(12);
      while (cpu_hold !== 1'b0) tick(1);
      tick(2);
      hlen = hcnt - h0;
   endtask : ev
   task automatic rng(input int lo, input int hi);
      chk({31'h0, (hlen >= lo) && (hlen <= hi)}, 32'h1);
   endtask : rng
   task automatic summarize();
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: whole sequence needs well under 5000 cycles
   initial begin
      #200000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(PS, ALL, 32'h0);
      rd(CS, ALL, 32'h18);
      rd(CF, ALL, 32'h0);
      // Power-on in crystal mode with power-up timer: both delays
      ev(0, 10);
      rng(44, 64);
      rd(PS, 32'h2, 32'h0);
      rd(CS, 32'hfffffff8, 32'h18);
      rd(CT, 32'h7, 32'(rcs_pkg::RCS_EV_POR));
      wr(PS, 32'h3);
      rd(PS, ALL, 32'h3);
      wr(CS, 32'he7);
      rd(CS, ALL, 32'hff);
      // External reset while running clears only the top three bits
      ev(2, 10);
      rd(CS, ALL, 32'h1f);
      rd(PS, ALL, 32'h3);
      rd(CT, 32'h20, 32'h0);
      wr(CF, 32'h2);
      rd(CT, 32'h20, 32'h20);
      ev(1, 10);
      rng(44, 64);
      rd(PS, ALL, 32'h2);
      rd(CS, 32'h18, 32'h18);
      rd(CT, 32'h7, 32'(rcs_pkg::RCS_EV_BOR));
      // Watchdog wake: oscillator delay only
      sleeping <= 1'b1;
      ev(3, 10);
      rng(24, 40);
      rd(CS, 32'h18, 32'h0);
      rd(PC, ALL, 32'h124);
      ev(2, 10);
      rd(CS, 32'h18, 32'h10);
      rd(PC, ALL, 32'h0);
      ev(4, 4);
      rd(PC, ALL, 32'h124);
      rd(PS, ALL, 32'h2);
      sleeping <= 1'b0;
      ev(3, 10);
      rd(CS, 32'h18, 32'h08);
      rd(PC, ALL, 32'h0);
      // Resistor-capacitor mode: no oscillator delay on wake
      wr(CF, 32'he);
      sleeping <= 1'b1;
      global_irq_enable <= 1'b1;
      ev(4, 4);
      rng(0, 0);
      rd(CS, 32'h18, 32'h10);
      rd(PC, ALL, 32'h4);
      sleeping <= 1'b0;
      global_irq_enable <= 1'b0;
      ev(1, 10);
      rng(16, 32);
      // Crystal power-on with the power-up timer disabled: oscillator delay only
      wr(CF, 32'h5);
      ev(0, 10);
      rng(24, 40);
      rd(PS, 32'h2, 32'h0);
      // Sticky status, mask and level output
      rd(IS, 32'hf, 32'hf);
      wr(IS, 32'hf);
      rd(IS, 32'hf, 32'h0);
      wr(IM, 32'h4);
      ev(3, 10);
      chk({31'h0, irq}, 32'h1);
      wr(IM, 32'h0);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      wr(IM, 32'h4);
      tick(2);
      chk({31'h0, irq}, 32'h1);
      wr(IS, 32'h4);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      // Unmapped and misaligned places answer with an error and zero
      rd(12'h01c, ALL, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      rd(12'h002, ALL, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      summarize();
   end
endmodule : testbench
`default_nettype wire
